//--- core/link_tx_cfg_pkg.sv
// Purpose: Constants and types for the link transmitter configuration registers
// Assumes: 16-bit register address, 8-bit register data
// Notes: Offsets are byte addresses on the plain register port
package link_tx_cfg_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] SAMPLES_PER_FRAME_OFS = 16'h0591;
	localparam logic [15:0] DENSITY_CW_OFS = 16'h0592;
	localparam logic [15:0] LANE0_CHECKSUM_OFS = 16'h05a0;
	localparam logic [15:0] LANE1_CHECKSUM_OFS = 16'h05a1;
	localparam logic [15:0] LANE_POWERDOWN_OFS = 16'h05b0;
	localparam logic [15:0] LANE0_MAPPING_OFS = 16'h05b2;
	localparam logic [15:0] LANE1_MAPPING_OFS = 16'h05b3;
	localparam logic [15:0] DRIVE_SWING_OFS = 16'h05c0;
	localparam logic [15:0] LANE0_PREEMPH_OFS = 16'h05c4;
	// Read-only field values
	localparam logic [2:0] SPF_RSVD_VAL = 3'h1;
	localparam logic [4:0] SPF_FIELD_DEF = 5'h00;
	localparam logic [0:0] HIGH_DENSITY_DEF = 1'h0;
	localparam logic [4:0] CW_PER_FRAME_DEF = 5'h00;
	localparam logic [7:0] LANE0_CHECKSUM_RST = 8'hc3;
	localparam logic [7:0] LANE1_CHECKSUM_RST = 8'hc4;
	// Field positions
	localparam int PD_LANE1_BIT = 2;
	localparam int PD_LANE0_BIT = 0;
	localparam int HD_BIT = 7;
	// Writable reset values and unmapped read value
	localparam logic [4:0] PD_RSVD_HI_RST = 5'h1f;
	localparam logic [0:0] PD_RSVD_B1_RST = 1'h1;
	localparam logic [2:0] MAP0_RSVD_RST = 3'h0;
	localparam logic [2:0] MAP1_RSVD_RST = 3'h1;
	localparam logic [2:0] MAP0_SEL_RST = 3'h0;
	localparam logic [2:0] MAP1_SEL_RST = 3'h1;
	localparam logic [2:0] SWING_RST = 3'h1;
	localparam logic [7:0] PREEMPH_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [2:0] sel;
		logic [2:0] swing;
		logic powerdown;
	} lane_ctl_t;
endpackage

//--- core/link_tx_cfg_regs.sv
// Purpose: Register bank for link transmitter config, lane map, power-down, swing
// Assumes: Synchronous active-high reset, single 100 MHz clock
//   lane parameter sums are steady levels
// Notes: Read data valid the cycle after the read strobe only
//   0x0591 samples per frame, read only
//   0x0592 density flag and control words per frame, read only
//   0x05a0 lane 0 checksum, read only
//   0x05a1 lane 1 checksum, read only
//   0x05b0 lane force power-down
//   0x05b2 output lane 0 mapping
//   0x05b3 output lane 1 mapping
//   0x05c0 output drive swing
//   0x05c4 lane 0 pre-emphasis, stored only
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module link_tx_cfg_regs
	import link_tx_cfg_pkg::*;
#(
	parameter logic [4:0] SAMPLES_PER_FRAME_FIELD = SPF_FIELD_DEF,
	parameter logic [4:0] CONTROL_WORDS_PER_FRAME = CW_PER_FRAME_DEF,
	parameter logic [0:0] HIGH_DENSITY_FLAG = HIGH_DENSITY_DEF
) (
	input wire logic core_clk_in, // 100 MHz clock
	input wire logic sys_rst_in, // Sync reset, active high
	input wire logic [15:0] reg_addr_in, // Register address
	input wire logic [7:0] reg_wdata_in, // Write data
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	input wire logic [7:0] lane0_param_sum_in, // Lane 0 sum of other link parameters
	input wire logic [7:0] lane1_param_sum_in, // Lane 1 sum of other link parameters
	output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
	output lane_ctl_t lane0_ctl_out, // Physical lane 0 controls
	output lane_ctl_t lane1_ctl_out // Physical lane 1 controls
);

	////////////////////////////////////////////////////////////////////////
	// Lane checksum: external sum plus the local link parameters, wrapped to a byte
	function automatic logic [7:0] cksum(input logic [7:0] ext, input logic [2:0] sel);
		logic [7:0] acc;
		acc = ext;
		acc = acc + {3'h0, SAMPLES_PER_FRAME_FIELD};
		acc = acc + {3'h0, CONTROL_WORDS_PER_FRAME};
		acc = acc + {7'h0, HIGH_DENSITY_FLAG};
		acc = acc + {5'h0, sel};
		cksum = acc;
	endfunction

	function automatic logic wr_hit(input reg_req_t r, input logic [15:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction

	function automatic logic [7:0] pair_byte(input logic [2:0] hi, input logic [2:0] lo);
		pair_byte = {1'b0, hi, 1'b0, lo};
	endfunction

	function automatic lane_ctl_t lane_word(input logic [2:0] sel, input logic [2:0] swing, input logic pd);
		lane_word = '{sel: sel, swing: swing, powerdown: pd};
	endfunction

	reg_req_t req;
	logic [4:0] pd_rsvd_hi_q;
	logic pd_rsvd_b1_q;
	logic pd_lane1_q;
	logic pd_lane0_q;
	logic [2:0] map0_rsvd_q;
	logic [2:0] map0_sel_q;
	logic [2:0] map1_rsvd_q;
	logic [2:0] map1_sel_q;
	logic [2:0] swing1_q;
	logic [2:0] swing0_q;
	logic [7:0] preemph0_q;
	logic [7:0] cksum0_q;
	logic [7:0] cksum1_q;
	logic [7:0] rdata_d;
	logic pd_we;
	logic map0_we;
	logic map1_we;
	logic swing_we;
	logic preemph_we;
	logic [7:0] spf_byte;
	logic [7:0] density_byte;
	logic [7:0] pd_byte;
	logic [7:0] map0_byte;
	logic [7:0] map1_byte;
	logic [7:0] swing_byte;
	lane_ctl_t lane0_d;
	lane_ctl_t lane1_d;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

	////////////////////////////////////////////////////////////////////////
	// Write decode; read-only offsets have no enable at all
	assign pd_we = wr_hit(req, LANE_POWERDOWN_OFS);
	assign map0_we = wr_hit(req, LANE0_MAPPING_OFS);
	assign map1_we = wr_hit(req, LANE1_MAPPING_OFS);
	assign swing_we = wr_hit(req, DRIVE_SWING_OFS);
	assign preemph_we = wr_hit(req, LANE0_PREEMPH_OFS);

	////////////////////////////////////////////////////////////////////////
	// Register images as software reads them
	assign spf_byte = {SPF_RSVD_VAL, SAMPLES_PER_FRAME_FIELD};
	always_comb begin
		density_byte = 8'h00;
		density_byte[HD_BIT] = HIGH_DENSITY_FLAG;
		density_byte[4:0] = CONTROL_WORDS_PER_FRAME;
	end
	always_comb begin
		pd_byte = {pd_rsvd_hi_q, 3'h0};
		pd_byte[PD_LANE1_BIT] = pd_lane1_q;
		pd_byte[1] = pd_rsvd_b1_q;
		pd_byte[PD_LANE0_BIT] = pd_lane0_q;
	end
	assign map0_byte = pair_byte(map0_rsvd_q, map0_sel_q);
	assign map1_byte = pair_byte(map1_rsvd_q, map1_sel_q);
	assign swing_byte = pair_byte(swing1_q, swing0_q);

	////////////////////////////////////////////////////////////////////////
	// Next lane control words
	assign lane0_d = lane_word(map0_sel_q, swing0_q, pd_lane0_q);
	assign lane1_d = lane_word(map1_sel_q, swing1_q, pd_lane1_q);

	////////////////////////////////////////////////////////////////////////
	// Power-down register; reserved bits are plain storage
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pd_rsvd_hi_q <= PD_RSVD_HI_RST;
			pd_rsvd_b1_q <= PD_RSVD_B1_RST;
		end else if (pd_we) begin
			pd_rsvd_hi_q <= req.wdata[7:3];
			pd_rsvd_b1_q <= req.wdata[1];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pd_lane1_q <= 1'b0;
			pd_lane0_q <= 1'b0;
		end else if (pd_we) begin
			pd_lane1_q <= req.wdata[PD_LANE1_BIT];
			pd_lane0_q <= req.wdata[PD_LANE0_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lane mapping registers; bits 7 and 3 are read-only zero
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			map0_rsvd_q <= MAP0_RSVD_RST;
		end else if (map0_we) begin
			map0_rsvd_q <= req.wdata[6:4];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			map0_sel_q <= MAP0_SEL_RST;
		end else if (map0_we) begin
			map0_sel_q <= req.wdata[2:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			map1_rsvd_q <= MAP1_RSVD_RST;
		end else if (map1_we) begin
			map1_rsvd_q <= req.wdata[6:4];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			map1_sel_q <= MAP1_SEL_RST;
		end else if (map1_we) begin
			map1_sel_q <= req.wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drive swing register
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			swing1_q <= SWING_RST;
		end else if (swing_we) begin
			swing1_q <= req.wdata[6:4];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			swing0_q <= SWING_RST;
		end else if (swing_we) begin
			swing0_q <= req.wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pre-emphasis byte stored only, not decoded here
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			preemph0_q <= PREEMPH_RST;
		end else if (preemph_we) begin
			preemph0_q <= req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checksums follow each lane's current assignment, one cycle behind
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cksum0_q <= LANE0_CHECKSUM_RST;
		end else begin
			cksum0_q <= cksum(lane0_param_sum_in, map0_sel_q);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cksum1_q <= LANE1_CHECKSUM_RST;
		end else begin
			cksum1_q <= cksum(lane1_param_sum_in, map1_sel_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; read-only fields come from constants or the checksum registers, never from writes
	always_comb begin
		unique case (req.addr)
			SAMPLES_PER_FRAME_OFS: begin
				rdata_d = spf_byte;
			end
			DENSITY_CW_OFS: begin
				rdata_d = density_byte;
			end
			LANE0_CHECKSUM_OFS: begin
				rdata_d = cksum0_q;
			end
			LANE1_CHECKSUM_OFS: begin
				rdata_d = cksum1_q;
			end
			LANE_POWERDOWN_OFS: begin
				rdata_d = pd_byte;
			end
			LANE0_MAPPING_OFS: begin
				rdata_d = map0_byte;
			end
			LANE1_MAPPING_OFS: begin
				rdata_d = map1_byte;
			end
			DRIVE_SWING_OFS: begin
				rdata_d = swing_byte;
			end
			LANE0_PREEMPH_OFS: begin
				rdata_d = preemph0_q;
			end
			default: begin
				rdata_d = UNMAPPED_RD;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (req.rd) begin
			reg_rdata_out <= rdata_d;
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lane control outputs, registered, one block per physical lane
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			lane0_ctl_out <= lane_word(MAP0_SEL_RST, SWING_RST, 1'b0);
		end else begin
			lane0_ctl_out <= lane0_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			lane1_ctl_out <= lane_word(MAP1_SEL_RST, SWING_RST, 1'b0);
		end else begin
			lane1_ctl_out <= lane1_d;
		end
	end

endmodule

//--- testbench/lane_rx_model.sv
// Purpose: Far-end receiver view of lane parameter sums
// Assumes: Sums are static link settings
// Notes: Feeds the checksum inputs
`timescale 1ns/1ns
module lane_rx_model #(
	parameter logic [7:0] LANE0_SUM = 8'h35,
	parameter logic [7:0] LANE1_SUM = 8'h5a
) (
	output logic [7:0] lane0_sum_out, // Lane 0 sum
	output logic [7:0] lane1_sum_out // Lane 1 sum
);
	assign lane0_sum_out = LANE0_SUM;
	assign lane1_sum_out = LANE1_SUM;
endmodule

//--- testbench/link_tx_cfg_regs_asserts.sv
// Purpose: Port checks for the config bank
// Assumes: One clock, sync reset
// Notes: Bound below
`timescale 1ns/1ns
module link_tx_cfg_regs_asserts
	import link_tx_cfg_pkg::*;
#(
	parameter logic [4:0] SAMPLES_PER_FRAME_FIELD = 5'h00,
	parameter logic [4:0] CONTROL_WORDS_PER_FRAME = 5'h00,
	parameter logic [0:0] HIGH_DENSITY_FLAG = 1'h0
) (
	input wire logic core_clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic [15:0] reg_addr_in, // Address
	input wire logic [7:0] reg_wdata_in, // Data
	input wire logic reg_wr_in, // Write
	input wire logic reg_rd_in, // Read
	input wire logic [7:0] reg_rdata_out, // Read data
	input wire lane_ctl_t lane0_ctl_out, // Lane 0
	input wire lane_ctl_t lane1_ctl_out // Lane 1
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00) else $error("rdata not idle");
	spf_read_a: assert property (reg_rd_in && reg_addr_in == SAMPLES_PER_FRAME_OFS
		|=> reg_rdata_out == {SPF_RSVD_VAL, SAMPLES_PER_FRAME_FIELD}) else $error("spf bad");
	cw_read_a: assert property (reg_rd_in && reg_addr_in == DENSITY_CW_OFS
		|=> reg_rdata_out == {HIGH_DENSITY_FLAG, 2'b00, CONTROL_WORDS_PER_FRAME}) else $error("cw bad");
	pd_lanes_a: assert property (reg_wr_in && reg_addr_in == LANE_POWERDOWN_OFS
		|=> ##1 lane1_ctl_out.powerdown == $past(reg_wdata_in[PD_LANE1_BIT], 2)
		&& lane0_ctl_out.powerdown == $past(reg_wdata_in[PD_LANE0_BIT], 2)) else $error("pd bad");
	map_zero_a: assert property (reg_wr_in && reg_addr_in == LANE0_MAPPING_OFS
		|=> ##1 lane0_ctl_out.sel == $past(reg_wdata_in[2:0], 2)) else $error("map0 bad");
	map_one_a: assert property (reg_wr_in && reg_addr_in == LANE1_MAPPING_OFS
		|=> ##1 lane1_ctl_out.sel == $past(reg_wdata_in[2:0], 2)) else $error("map1 bad");
	swing_a: assert property (reg_wr_in && reg_addr_in == DRIVE_SWING_OFS
		|=> ##1 lane1_ctl_out.swing == $past(reg_wdata_in[6:4], 2)
		&& lane0_ctl_out.swing == $past(reg_wdata_in[2:0], 2)) else $error("swing bad");
	ctl_hold_a: assert property (!reg_wr_in |=> ##1 $stable({lane0_ctl_out, lane1_ctl_out})) else $error("ctl moved");
endmodule
bind link_tx_cfg_regs link_tx_cfg_regs_asserts #(.SAMPLES_PER_FRAME_FIELD(SAMPLES_PER_FRAME_FIELD),
	.CONTROL_WORDS_PER_FRAME(CONTROL_WORDS_PER_FRAME), .HIGH_DENSITY_FLAG(HIGH_DENSITY_FLAG)) u_chk (
	.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.lane0_ctl_out, .lane1_ctl_out);

//--- testbench/tb_top.sv
// Purpose: Random register traffic against a bench model
// Assumes: Defaults of the receiver sums
// Notes: Checksum adds field 0x0b, 0x03 and lane sel
`timescale 1ns/1ns
module tb_top;
	import link_tx_cfg_pkg::*;
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	reg_req_t req = '0;
	logic [7:0] s0, s1, rdata;
	lane_ctl_t c0, c1;
	int err_total = 0;
	int n_compared = 0;
	int m0 [int] = '{16'h05b0: 8'hfa, 16'h05b2: 0, 16'h05b3: 8'h11, 16'h05c0: 8'h11, 16'h05c4: 0};
	int m [int];
	logic [15:0] adr [11] = '{16'h0591, 16'h0592, 16'h05a0, 16'h05a1, 16'h05b0, 16'h05b2, 16'h05b3,
		16'h05c0, 16'h05c4, 16'h05a8, 16'h0600};
	always #5 core_clk_in = ~core_clk_in;
	lane_rx_model i_rx (.lane0_sum_out(s0), .lane1_sum_out(s1));
	link_tx_cfg_regs #(.SAMPLES_PER_FRAME_FIELD(5'h0b), .CONTROL_WORDS_PER_FRAME(5'h03)) i_dut (.core_clk_in,
		.sys_rst_in, .reg_addr_in(req.addr), .reg_wdata_in(req.wdata), .reg_wr_in(req.wr), .reg_rd_in(req.rd),
		.lane0_param_sum_in(s0), .lane1_param_sum_in(s1), .reg_rdata_out(rdata), .lane0_ctl_out(c0),
		.lane1_ctl_out(c1));
	function automatic int msk(input int a);
		case (a)
			16'h05b0, 16'h05c4: return 8'hff;
			16'h05b2, 16'h05b3, 16'h05c0: return 8'h77;
			default: return 0;
		endcase
	endfunction
	function automatic logic [7:0] expv(input int a);
		case (a)
			16'h0591: return 8'h2b;
			16'h0592: return 8'h03;
			16'h05a0: return 8'(int'(s0) + 14 + m[16'h05b2] % 8);
			16'h05a1: return 8'(int'(s1) + 14 + m[16'h05b3] % 8);
			default: return m.exists(a) ? 8'(m[a]) : 8'h00;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk_in);
		req.wr <= 1'b0;
		if (msk(a) != 0) m[a] = (m[a] & ~msk(a)) | (d & msk(a));
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk_in);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk_in);
		req.rd <= 1'b0;
		#1;
		chk("rdata", rdata, expv(a));
		chk("lane0", {1'b0, c0}, {1'b0, 3'(m[16'h05b2]), 3'(m[16'h05c0]), 1'(m[16'h05b0])});
		chk("lane1", {1'b0, c1}, {1'b0, 3'(m[16'h05b3]), 3'(m[16'h05c0] >> 4), 1'(m[16'h05b0] >> 2)});
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(66));
		m = m0;
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		foreach (adr[i]) rd(adr[i]);
		foreach (adr[i]) wr(adr[i], 8'hff);
		foreach (adr[i]) rd(adr[i]);
		repeat (60) begin
			wr(adr[$urandom_range(10)], 8'($urandom));
			rd(adr[$urandom_range(10)]);
		end
		@(posedge core_clk_in);
		sys_rst_in <= 1'b1;
		@(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		m = m0;
		foreach (adr[i]) rd(adr[i]);
		summarize();
	end
endmodule
